// *** apd_driver.sv ***
// audio pwm driver: ahb-lite registers, gain, mute and two-pin pwm output
module apd_driver
   import apd_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic low_power_mode,
   input wire apd_ahb_req_t ahb_req,
   output apd_ahb_rsp_t ahb_rsp,
   output apd_spk_t speaker
);

   apd_state_t s_ff;
   apd_state_t nxt_s;
   logic [10:0] gain;
   logic active;
   logic [15:0] sample_eff;
   logic signed [15:0] centred;
   logic signed [27:0] product;
   logic signed [27:0] shifted;
   logic [15:0] saturated;
   logic [15:0] scaled;
   logic [8:0] new_duty;
   logic pwm_level;
   apd_width_t wsel;
   apd_drive_mode_t mode;
   logic addr_phase;

   // top count of the counter for a given width
   function automatic logic [8:0] top_count(input apd_width_t w);
      case (w)
         APD_W6: top_count = 9'h03f;
         APD_W7: top_count = 9'h07f;
         APD_W8: top_count = 9'h0ff;
         APD_W9: top_count = 9'h1ff;
         default: top_count = 9'h03f;
      endcase
   endfunction

   // upper N bits of the scaled sample
   function automatic logic [8:0] effective_bits(input logic [15:0] v, input apd_width_t w);
      case (w)
         APD_W6: effective_bits = {3'h0, v[15:10]};
         APD_W7: effective_bits = {2'h0, v[15:9]};
         APD_W8: effective_bits = {1'h0, v[15:8]};
         APD_W9: effective_bits = v[15:7];
         default: effective_bits = {3'h0, v[15:10]};
      endcase
   endfunction

   function automatic logic [7:0] read_mux(input logic [7:0] addr, input apd_state_t st);
      case (addr)
         OFS_VOLUME: read_mux = st.volume_mute_control;
         OFS_DRIVE: read_mux = st.audio_drive_control & DRIVE_WMASK;
         OFS_SAMPLE_LOW: read_mux = st.play_sample_low;
         OFS_SAMPLE_HIGH: read_mux = st.play_sample_high;
         default: read_mux = 8'h00;
      endcase
   endfunction

   apd_gain_lut u_gain (
      .clk(clk),
      .rstn(rstn),
      .volume_gain_code(s_ff.volume_mute_control[GAIN_CODE_MSB:0]),
      .gain(gain)
   );

   always_comb begin
      nxt_s = s_ff;
      wsel = apd_width_t'(s_ff.audio_drive_control[WSEL_MSB:WSEL_LSB]);
      mode = apd_drive_mode_t'(s_ff.audio_drive_control[MODE_BIT]);
      active = s_ff.audio_drive_control[ENABLE_BIT] & ~low_power_mode;

      // mute swaps in the mid-scale code before any scaling
      sample_eff = s_ff.volume_mute_control[UNMUTE_BIT] ? s_ff.sample : SILENCE_CODE;

      // offset binary to signed, scale, saturate, back to offset binary
      centred = $signed({~sample_eff[15], sample_eff[14:0]});
      product = centred * $signed({1'b0, gain});
      shifted = product >>> GAIN_FRAC;
      if (shifted > SAT_MAX) begin
         saturated = 16'h7fff;
      end else if (shifted < SAT_MIN) begin
         saturated = 16'h8000;
      end else begin
         saturated = shifted[15:0];
      end
      scaled = {~saturated[15], saturated[14:0]};
      new_duty = effective_bits(scaled, wsel);

      // register writes in the data phase
      if (s_ff.dph_valid && s_ff.dph_write) begin
         case (s_ff.dph_addr)
            OFS_VOLUME: nxt_s.volume_mute_control = ahb_req.hwdata[7:0];
            OFS_DRIVE: nxt_s.audio_drive_control = ahb_req.hwdata[7:0] & DRIVE_WMASK;
            OFS_SAMPLE_LOW: nxt_s.play_sample_low = ahb_req.hwdata[7:0];
            OFS_SAMPLE_HIGH: begin
               nxt_s.play_sample_high = ahb_req.hwdata[7:0];
               // low byte alone never reaches the pwm stage
               nxt_s.sample = {ahb_req.hwdata[7:0], s_ff.play_sample_low};
            end
            default: begin
            end
         endcase
      end

      // address phase; read data taken from the post-write values so a read
      // right behind a write sees the new contents without a wait state
      addr_phase = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);
      nxt_s.dph_valid = addr_phase;
      nxt_s.dph_write = ahb_req.hwrite;
      nxt_s.dph_addr = ahb_req.haddr[7:0];
      if (addr_phase && !ahb_req.hwrite) begin
         nxt_s.rsp.hrdata = {24'h000000, read_mux(ahb_req.haddr[7:0], nxt_s)};
      end
      nxt_s.rsp.hreadyout = 1'b1;
      nxt_s.rsp.hresp = HRESP_OKAY;

      // pwm stage
      pwm_level = s_ff.cnt < s_ff.duty;
      if (!active) begin
         nxt_s.cnt = 9'h000;
         nxt_s.phase = 1'b0;
         nxt_s.duty = new_duty;
         nxt_s.pins = '{speaker_out_a: 1'b0, speaker_oe_a_n: 1'b1,
                        speaker_out_b: 1'b0, speaker_oe_b_n: 1'b1};
      end else begin
         nxt_s.pins.speaker_oe_a_n = 1'b0;
         nxt_s.pins.speaker_oe_b_n = 1'b0;
         if (mode == APD_DRV_GREEN) begin
            nxt_s.pins.speaker_out_a = pwm_level & ~s_ff.phase;
            nxt_s.pins.speaker_out_b = pwm_level & s_ff.phase;
         end else begin
            nxt_s.pins.speaker_out_a = pwm_level;
            nxt_s.pins.speaker_out_b = pwm_level;
         end
         // duty only changes at a period boundary to keep pulses whole
         if (s_ff.cnt >= top_count(wsel)) begin
            nxt_s.cnt = 9'h000;
            nxt_s.duty = new_duty;
            nxt_s.phase = ~s_ff.phase;
         end else begin
            nxt_s.cnt = s_ff.cnt + 9'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_ff <= '{volume_mute_control: VOLUME_RST,
                   audio_drive_control: DRIVE_RST,
                   play_sample_low: SAMPLE_BYTE_RST,
                   play_sample_high: SAMPLE_BYTE_RST,
                   sample: SAMPLE_RST,
                   dph_valid: 1'b0,
                   dph_write: 1'b0,
                   dph_addr: 8'h00,
                   rsp: '{hreadyout: 1'b1, hresp: HRESP_OKAY, hrdata: 32'h00000000},
                   cnt: 9'h000,
                   duty: 9'h000,
                   phase: 1'b0,
                   pins: '{speaker_out_a: 1'b0, speaker_oe_a_n: 1'b1,
                           speaker_out_b: 1'b0, speaker_oe_b_n: 1'b1}};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ahb_rsp = s_ff.rsp;
   assign speaker = s_ff.pins;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic dph_wr_high;
   logic dph_wr_low;
   logic dph_rd_drive;
   assign dph_wr_high = s_ff.dph_valid && s_ff.dph_write && (s_ff.dph_addr == OFS_SAMPLE_HIGH);
   assign dph_wr_low = s_ff.dph_valid && s_ff.dph_write && (s_ff.dph_addr == OFS_SAMPLE_LOW);
   assign dph_rd_drive = s_ff.dph_valid && !s_ff.dph_write && (s_ff.dph_addr == OFS_DRIVE);

   AST_FLOAT_WHEN_DISABLED: assert property (
      !s_ff.audio_drive_control[ENABLE_BIT] |=> speaker.speaker_oe_a_n && speaker.speaker_oe_b_n
                                                && !speaker.speaker_out_a && !speaker.speaker_out_b)
      else $error("speaker pins driven while driver disabled");

   AST_LOW_POWER_OFF: assert property (
      low_power_mode |=> speaker.speaker_oe_a_n && speaker.speaker_oe_b_n && s_ff.cnt == 9'h000)
      else $error("driver still running in idle or sleep");

   AST_DRIVE_WHEN_ACTIVE: assert property (
      active |=> !speaker.speaker_oe_a_n && !speaker.speaker_oe_b_n)
      else $error("speaker pins not driven while active");

   AST_MUTE_SILENCE: assert property (
      !s_ff.volume_mute_control[UNMUTE_BIT] |-> sample_eff == SILENCE_CODE)
      else $error("muted path not at mid scale");

   AST_GAIN_ZERO_DB: assert property (
      (s_ff.volume_mute_control[GAIN_CODE_MSB:0] == 7'h00) [*2] |-> gain == GAIN_UNITY)
      else $error("zero volume code is not unity gain");

   AST_GAIN_BOTTOM: assert property (
      (s_ff.volume_mute_control[GAIN_CODE_MSB:0] == 7'h54) [*2] |-> gain == 11'h00d)
      else $error("lowest volume code has wrong gain");

   AST_NORMAL_BOTH: assert property (
      $past(active) && $past(mode) == APD_DRV_NORMAL
      |-> speaker.speaker_out_a == speaker.speaker_out_b)
      else $error("normal mode pins differ");

   AST_GREEN_ALTERNATE: assert property (
      $past(active) && $past(mode) == APD_DRV_GREEN
      |-> !(speaker.speaker_out_a && speaker.speaker_out_b)
          && (speaker.speaker_out_a ? !$past(s_ff.phase) : 1'b1))
      else $error("green mode drives both pins at once");

   AST_PERIOD_WRAP: assert property (
      active && s_ff.cnt == top_count(wsel) ##1 active |-> s_ff.cnt == 9'h000)
      else $error("counter period wrong for selected width");

   AST_DUTY_BITS: assert property (
      active && s_ff.cnt >= top_count(wsel) |=> s_ff.duty == $past(new_duty)
                                               && s_ff.duty <= top_count($past(wsel)))
      else $error("duty not taken from upper sample bits");

   AST_RESERVED_ZERO: assert property (
      dph_rd_drive |-> ahb_rsp.hrdata[4:1] == 4'h0 && ahb_rsp.hrdata[31:8] == 24'h000000)
      else $error("reserved control bits read nonzero");

   AST_LOW_HELD: assert property (
      dph_wr_low && !dph_wr_high |=> s_ff.sample == $past(s_ff.sample))
      else $error("low byte write leaked into pwm sample");

   AST_HIGH_COMMIT: assert property (
      dph_wr_high |=> s_ff.sample == {$past(ahb_req.hwdata[7:0]), $past(s_ff.play_sample_low)})
      else $error("high byte write did not commit full sample");

   AST_PINS_NEED_ACTIVE: assert property (
      !speaker.speaker_oe_a_n || !speaker.speaker_oe_b_n |-> $past(active))
      else $error("speaker pins driven without an active driver");

   AST_IDLE_COUNTER: assert property (
      !active |=> s_ff.cnt == 9'h000 && !s_ff.phase)
      else $error("counter not parked while driver off");

   AST_CNT_STEP: assert property (
      active && s_ff.cnt < top_count(wsel) |=> s_ff.cnt == $past(s_ff.cnt) + 9'h001)
      else $error("pwm counter skipped a count");

   AST_DUTY_HELD: assert property (
      active && s_ff.cnt < top_count(wsel) |=> $stable(s_ff.duty))
      else $error("duty changed inside a pwm period");

   AST_GREEN_TOGGLE: assert property (
      active && mode == APD_DRV_GREEN && s_ff.cnt >= top_count(wsel)
      |=> s_ff.phase != $past(s_ff.phase))
      else $error("green mode did not hand over to the other pin");

   AST_NORMAL_LEVEL: assert property (
      active && mode == APD_DRV_NORMAL
      |=> speaker.speaker_out_a == ($past(s_ff.cnt) < $past(s_ff.duty)))
      else $error("normal mode pin level does not follow the counter");

   AST_GAIN_TOP: assert property (
      (s_ff.volume_mute_control[GAIN_CODE_MSB:0] == 7'h0c) [*2] |-> gain == 11'h400)
      else $error("top volume code is not plus six dB");

   AST_GAIN_MINUS_6: assert property (
      (s_ff.volume_mute_control[GAIN_CODE_MSB:0] == 7'h74) [*2] |-> gain == 11'h100)
      else $error("minus six dB volume code has wrong gain");

   AST_DRIVE_RESERVED_CLEAR: assert property (
      s_ff.audio_drive_control[4:1] == 4'h0)
      else $error("unimplemented control bits hold a one");

   AST_SILENT_DUTY: assert property (
      !s_ff.volume_mute_control[UNMUTE_BIT] |-> new_duty == effective_bits(SILENCE_CODE, wsel))
      else $error("muted duty is not mid scale");

   COV_GREEN_RUN: cover property (active && mode == APD_DRV_GREEN && speaker.speaker_out_b);
   COV_MUTED_RUN: cover property (active && !s_ff.volume_mute_control[UNMUTE_BIT] [*4]);
   COV_WIDTH9_WRAP: cover property (active && wsel == APD_W9 && s_ff.cnt == 9'h1ff);
   COV_SAMPLE_PAIR: cover property (dph_wr_low ##[1:20] dph_wr_high);
   COV_LOW_POWER_CUT: cover property (s_ff.audio_drive_control[ENABLE_BIT] && low_power_mode);

endmodule // apd_driver

// *** apd_pkg.sv ***
// shared constants, types and register map of the audio pwm driver
package apd_pkg;

   // ahb-lite transfer encoding
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // register byte offsets inside the slave window
   localparam logic [7:0] OFS_VOLUME = 8'h00;
   localparam logic [7:0] OFS_DRIVE = 8'h04;
   localparam logic [7:0] OFS_SAMPLE_LOW = 8'h08;
   localparam logic [7:0] OFS_SAMPLE_HIGH = 8'h0c;

   // field positions
   localparam int UNMUTE_BIT = 7;
   localparam int GAIN_CODE_MSB = 6;
   localparam int MODE_BIT = 7;
   localparam int WSEL_MSB = 6;
   localparam int WSEL_LSB = 5;
   localparam int ENABLE_BIT = 0;
   localparam logic [7:0] DRIVE_WMASK = 8'he1;

   // reset values and the mid-scale code that mute swaps in
   localparam logic [7:0] VOLUME_RST = 8'h00;
   localparam logic [7:0] DRIVE_RST = 8'h00;
   localparam logic [7:0] SAMPLE_BYTE_RST = 8'h00;
   localparam logic [15:0] SAMPLE_RST = 16'h0000;
   localparam logic [15:0] SILENCE_CODE = 16'h8000;

   // gain arithmetic: gain word is q2.9, so 0 dB is 512
   localparam int GAIN_FRAC = 9;
   localparam logic [10:0] GAIN_UNITY = 11'h200;
   localparam int CODE_TOP = 12;
   localparam int CODE_HALF_LOW = -24;
   localparam int CODE_BOTTOM = -44;
   localparam int STEPS_PER_OCTAVE = 12;
   localparam int HALF_STEP_ZERO_DB = 12;
   localparam logic signed [27:0] SAT_MAX = 28'sh0007fff;
   localparam logic signed [27:0] SAT_MIN = -28'sh0008000;

   typedef enum logic {
      APD_DRV_NORMAL = 1'b0,
      APD_DRV_GREEN = 1'b1
   } apd_drive_mode_t;

   typedef enum logic [1:0] {
      APD_W6 = 2'b00,
      APD_W7 = 2'b01,
      APD_W8 = 2'b10,
      APD_W9 = 2'b11
   } apd_width_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } apd_ahb_req_t;

   typedef struct packed {
      logic hreadyout;
      logic [1:0] hresp;
      logic [31:0] hrdata;
   } apd_ahb_rsp_t;

   typedef struct packed {
      logic speaker_out_a;
      logic speaker_oe_a_n;
      logic speaker_out_b;
      logic speaker_oe_b_n;
   } apd_spk_t;

   typedef struct packed {
      logic [7:0] volume_mute_control;
      logic [7:0] audio_drive_control;
      logic [7:0] play_sample_low;
      logic [7:0] play_sample_high;
      logic [15:0] sample;
      logic dph_valid;
      logic dph_write;
      logic [7:0] dph_addr;
      apd_ahb_rsp_t rsp;
      logic [8:0] cnt;
      logic [8:0] duty;
      logic phase;
      apd_spk_t pins;
   } apd_state_t;

   typedef struct packed {
      logic [10:0] gain;
   } apd_gain_state_t;

endpackage

// *** apd_gain_lut.sv ***
// volume code to linear gain lookup with registered output
module apd_gain_lut
   import apd_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [6:0] volume_gain_code,
   output logic [10:0] gain
);

   apd_gain_state_t s_ff;
   apd_gain_state_t nxt_s;

   // 0.5 dB treated as a twelfth of an octave, well inside the stated tolerance
   function automatic int mantissa(input int idx);
      case (idx)
         0: mantissa = 1024;
         1: mantissa = 967;
         2: mantissa = 912;
         3: mantissa = 861;
         4: mantissa = 813;
         5: mantissa = 767;
         6: mantissa = 724;
         7: mantissa = 683;
         8: mantissa = 645;
         9: mantissa = 609;
         10: mantissa = 575;
         11: mantissa = 542;
         default: mantissa = 1024;
      endcase
   endfunction

   // half-dB steps below +6 dB
   function automatic int half_steps(input logic [6:0] code);
      int c;
      c = int'($signed(code));
      if (c <= CODE_TOP && c >= CODE_HALF_LOW) begin
         half_steps = CODE_TOP - c;
      end else if (c < CODE_HALF_LOW && c >= CODE_BOTTOM) begin
         half_steps = -2 * c - CODE_TOP;
      end else begin
         // reserved codes play at 0 dB
         half_steps = HALF_STEP_ZERO_DB;
      end
   endfunction

   always_comb begin
      int h;
      h = half_steps(volume_gain_code);
      nxt_s = s_ff;
      // rounded, not truncated, so the deepest settings stay on their nominal level
      nxt_s.gain = 11'((mantissa(h % STEPS_PER_OCTAVE) + ((1 << (h / STEPS_PER_OCTAVE)) >> 1))
                       >> (h / STEPS_PER_OCTAVE));
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_ff <= '{gain: GAIN_UNITY};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign gain = s_ff.gain;

endmodule // apd_gain_lut

// *** apd_speaker_model.sv ***
// loudspeaker model: resolves both speaker pins and tallies their levels
module apd_speaker_model
   import apd_pkg::*;
(
   input wire logic clk,
   input wire logic clr,
   input wire apd_spk_t speaker,
   output logic [15:0] cnt_a,
   output logic [15:0] cnt_b,
   output logic [15:0] cnt_both,
   output logic [15:0] cnt_z
);
   timeunit 1ns;
   timeprecision 1ns;
   wire pin_a;
   wire pin_b;
   // the coil has no pull, so a released pin reads z
   assign pin_a = speaker.speaker_oe_a_n ? 1'bz : speaker.speaker_out_a;
   assign pin_b = speaker.speaker_oe_b_n ? 1'bz : speaker.speaker_out_b;
   always @(posedge clk) begin
      if (clr) begin
         cnt_a <= 16'h0000;
         cnt_b <= 16'h0000;
         cnt_both <= 16'h0000;
         cnt_z <= 16'h0000;
      end else begin
         cnt_a <= cnt_a + 16'(pin_a === 1'b1);
         cnt_b <= cnt_b + 16'(pin_b === 1'b1);
         cnt_both <= cnt_both + 16'(pin_a === 1'b1 && pin_b === 1'b1);
         cnt_z <= cnt_z + 16'(pin_a === 1'bz && pin_b === 1'bz);
      end
   end
endmodule // apd_speaker_model

// *** test_audio_pwm_driver.sv ***
// self-checking testbench of the audio pwm driver
module test_audio_pwm_driver
   import apd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, lpm, clr, snap, rd_dph;
   apd_ahb_req_t m;
   apd_ahb_req_t req;
   apd_ahb_rsp_t rsp;
   apd_spk_t spk;
   logic [15:0] cnt_a, cnt_b, cnt_both, cnt_z;
   logic [15:0] exp_q[$];
   logic [31:0] lfsr_st;
   int miscompares, samples_checked;

   // single slave, so its hreadyout is the bus hready
   assign req = {m[$bits(apd_ahb_req_t)-1:1], rsp.hreadyout};

   apd_driver DUT (.clk(clk), .rstn(rstn), .low_power_mode(lpm), .ahb_req(req),
      .ahb_rsp(rsp), .speaker(spk));
   apd_speaker_model spkr (.clk(clk), .clr(clr), .speaker(spk), .cnt_a(cnt_a), .cnt_b(cnt_b),
      .cnt_both(cnt_both), .cnt_z(cnt_z));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rnd8(output logic [7:0] v);
      lfsr_st = lfsr_next(lfsr_st);
      v = lfsr_st[7:0];
   endtask

   task automatic check(input string what, input logic [15:0] exp_v, input logic [15:0] got);
      samples_checked++;
      if (got !== exp_v) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp_v, got);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      m.hsel <= 1'b1;
      m.htrans <= HTRANS_NONSEQ;
      m.haddr <= {24'h000000, a};
      m.hwrite <= wr;
      m.hsize <= 3'h2;
      do @(posedge clk); while (rsp.hreadyout !== 1'b1);
      m.hsel <= 1'b0;
      m.htrans <= 2'h0;
      m.hwdata <= {24'h000000, d};
      do @(posedge clk); while (rsp.hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      bus(1'b0, a, 8'h00);
   endtask

   task automatic cfg(input logic [7:0] vol, input logic [7:0] drv, input logic [15:0] smp);
      wr(OFS_DRIVE, drv);
      wr(OFS_VOLUME, vol);
      wr(OFS_SAMPLE_LOW, smp[7:0]);
      wr(OFS_SAMPLE_HIGH, smp[15:8]);
   endtask

   // a window of whole periods makes the tally independent of phase
   task automatic meas(input int n, input logic [15:0] duty, input logic green, input logic off);
      int w;
      w = 4 << n;
      repeat (2 * (1 << n) + 8) @(posedge clk);
      exp_q.push_back(off ? 16'h0000 : (green ? 16'(2 * duty) : 16'(4 * duty)));
      exp_q.push_back(off ? 16'h0000 : (green ? 16'(2 * duty) : 16'(4 * duty)));
      exp_q.push_back((off || green) ? 16'h0000 : 16'(4 * duty));
      exp_q.push_back(off ? 16'(w) : 16'h0000);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (w) @(posedge clk);
      snap <= 1'b1;
      @(posedge clk);
      snap <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (rd_dph && rsp.hreadyout === 1'b1) begin
         check("hrdata", exp_q.pop_front(), rsp.hrdata[15:0]);
         check("hrdata upper", 16'h0000, rsp.hrdata[31:16]);
         check("hresp", 16'(HRESP_OKAY), 16'(rsp.hresp));
      end
      if (snap) begin
         check("high cycles a", exp_q.pop_front(), cnt_a);
         check("high cycles b", exp_q.pop_front(), cnt_b);
         check("both high cycles", exp_q.pop_front(), cnt_both);
         check("floating cycles", exp_q.pop_front(), cnt_z);
      end
      rd_dph <= (rd_dph && rsp.hreadyout !== 1'b1) || (rstn && m.hsel && !m.hwrite
         && m.htrans == HTRANS_NONSEQ && rsp.hreadyout === 1'b1);
   end

   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      give_verdict();
   end

   initial begin
      logic [7:0] r;
      logic [15:0] smp;
      static logic [7:0] codes[5] = '{8'h8c, 8'hf4, 8'hd4, 8'h8c, 8'h8c};
      static logic [15:0] smps[5] = '{16'ha000, 16'ha000, 16'hffff, 16'hf000, 16'h2000};
      static logic [15:0] duts[5] = '{16'h0180, 16'h0120, 16'h0106, 16'h01ff, 16'h0000};
      m = '0;
      lpm = 1'b0;
      clr = 1'b0;
      snap = 1'b0;
      rd_dph = 1'b0;
      rstn = 1'b0;
      lfsr_st = 32'h00000d1f;
      miscompares = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(OFS_VOLUME, VOLUME_RST);
      rd(OFS_DRIVE, DRIVE_RST);
      rd(OFS_SAMPLE_LOW, SAMPLE_BYTE_RST);
      rd(OFS_SAMPLE_HIGH, SAMPLE_BYTE_RST);
      wr(OFS_DRIVE, 8'hff);
      rd(OFS_DRIVE, 8'he1);
      wr(OFS_DRIVE, 8'h00);
      rnd8(r);
      wr(OFS_VOLUME, r);
      rd(OFS_VOLUME, r);
      rd(8'h10, 8'h00);
      $display("test registers done");
      for (int w = 0; w < 4; w++) begin
         rnd8(r);
         smp = {8'ha4, r};
         cfg(8'h80, {1'b0, 2'(w), 5'h01}, smp);
         meas(w + 6, 16'(smp >> (10 - w)), 1'b0, 1'b0);
      end
      $display("test widths done");
      cfg(8'h80, 8'hc1, 16'ha4ff);
      meas(8, 16'h00a4, 1'b1, 1'b0);
      $display("test green done");
      // mute sits ahead of the gain, so full gain must not move silence
      cfg(8'h0c, 8'h41, 16'hf000);
      meas(8, 16'h0080, 1'b0, 1'b0);
      $display("test mute done");
      for (int i = 0; i < 5; i++) begin
         cfg(codes[i], 8'h61, smps[i]);
         meas(9, duts[i], 1'b0, 1'b0);
      end
      $display("test gain done");
      cfg(8'h80, 8'h61, 16'ha000);
      wr(OFS_SAMPLE_LOW, 8'h80);
      meas(9, 16'h0140, 1'b0, 1'b0);
      wr(OFS_SAMPLE_HIGH, 8'ha0);
      meas(9, 16'h0141, 1'b0, 1'b0);
      $display("test sample pairing done");
      wr(OFS_DRIVE, 8'h60);
      meas(9, 16'h0000, 1'b0, 1'b1);
      wr(OFS_DRIVE, 8'h61);
      lpm <= 1'b1;
      meas(9, 16'h0000, 1'b0, 1'b1);
      lpm <= 1'b0;
      meas(9, 16'h0141, 1'b0, 1'b0);
      $display("test disable done");
      give_verdict();
   end
endmodule // test_audio_pwm_driver
